// *** pq_pkg.sv ***
// Shared types and constants for the integer and product/quotient unit
package pq_pkg;
  // ==========================================================
  // Widths
  localparam int XLEN = 32;
  localparam int RIDX = 5;
  localparam int NREGS = 32;
  localparam int NSETS = 2;
  localparam int HALF = 16;
  localparam int CNTW = 6;

  // ==========================================================
  // Divider iteration counts per operand_a width class
  localparam logic [CNTW-1:0] DIV_SKIP_8 = 6'h17;
  localparam logic [CNTW-1:0] DIV_SKIP_16 = 6'h0f;
  localparam logic [CNTW-1:0] DIV_SKIP_24 = 6'h07;
  localparam logic [CNTW-1:0] DIV_SKIP_32 = 6'h00;
  localparam logic [CNTW-1:0] DIV_RPT_8 = 6'h0b;
  localparam logic [CNTW-1:0] DIV_RPT_16 = 6'h12;
  localparam logic [CNTW-1:0] DIV_RPT_24 = 6'h19;
  localparam logic [CNTW-1:0] DIV_RPT_32 = 6'h20;
  localparam logic [CNTW-1:0] DIV_BITS = 6'h20;

  // ==========================================================
  // Operations and carriers
  typedef enum logic [4:0] {
    OP_AND = 5'h00,
    OP_OR = 5'h01,
    OP_XOR = 5'h02,
    OP_NOR = 5'h03,
    OP_SLL = 5'h04,
    OP_SRL = 5'h05,
    OP_SRA = 5'h06,
    OP_ADD = 5'h07,
    OP_SUB = 5'h08,
    OP_LEAD_ZERO = 5'h09,
    OP_LEAD_ONE = 5'h0a,
    OP_DADDR = 5'h0b,
    OP_MOVE_UPPER = 5'h0c,
    OP_MOVE_BOTTOM = 5'h0d,
    OP_PROD_PAIR = 5'h0e,
    OP_PROD_PAIR_U = 5'h0f,
    OP_ACC_PROD = 5'h10,
    OP_ACC_PROD_U = 5'h11,
    OP_DED_PROD = 5'h12,
    OP_DED_PROD_U = 5'h13,
    OP_PROD_GEN = 5'h14,
    OP_QUOT = 5'h15,
    OP_QUOT_U = 5'h16
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic set;
    logic [RIDX-1:0] ra;
    logic [RIDX-1:0] rb;
    logic [RIDX-1:0] rd;
    logic [XLEN-1:0] imm;
  } issue_t;

  typedef struct packed {
    logic en;
    logic set;
    logic [RIDX-1:0] idx;
    logic [XLEN-1:0] data;
  } wb_t;
endpackage

// *** general_register_file.sv ***
// Two-set general register file, two read ports, one write port
`timescale 1ns/1ps
module general_register_file import pq_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Read ports
  input wire logic rd_set,
  input wire logic [1:0][RIDX-1:0] rd_idx,
  output logic [1:0][XLEN-1:0] rd_data,
  // Write port
  input wire wb_t wr
);
  typedef struct packed {
    logic [NSETS-1:0][NREGS-1:0][XLEN-1:0] regs;
  } rf_st_t;

  rf_st_t s_r;
  rf_st_t s_nxt;

  // ==========================================================
  // Storage, entry zero stays zero
  always_comb begin
    s_nxt = s_r;
    if (wr.en && wr.idx != '0) begin
      s_nxt.regs[wr.set][wr.idx] = wr.data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Reads see the word being written this cycle
  for (genvar p = 0; p < 2; p++) begin : g_rd
    assign rd_data[p] = (wr.en && wr.set == rd_set && wr.idx != '0 &&
                         wr.idx == rd_idx[p]) ? wr.data :
                        s_r.regs[rd_set][rd_idx[p]];
  end
endmodule

// *** quotient_iterator.sv ***
// Early-in iterative divider, one quotient bit per clock
`timescale 1ns/1ps
module quotient_iterator import pq_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Request
  input wire logic start,
  input wire logic is_signed,
  input wire logic [XLEN-1:0] dividend,
  input wire logic [XLEN-1:0] divisor,
  // Progress and result
  output logic fin,
  output logic [CNTW-1:0] cnt_nxt,
  output logic [XLEN-1:0] quot,
  output logic [XLEN-1:0] remd
);
  typedef struct packed {
    logic [CNTW-1:0] cnt;
    logic [CNTW-1:0] pad;
    logic [XLEN-1:0] rem;
    logic [XLEN-1:0] q;
    logic [XLEN-1:0] d;
    logic neg_q;
    logic neg_r;
  } dv_st_t;

  dv_st_t s_r;
  dv_st_t s_nxt;
  logic [XLEN-1:0] mag_a;
  logic [XLEN-1:0] mag_b;
  logic [CNTW-1:0] rpt;
  logic [CNTW-1:0] skip;
  logic [XLEN:0] sh;
  logic ge;
  logic [XLEN-1:0] it_rem;
  logic [XLEN-1:0] it_q;

  // ==========================================================
  // Width class and iteration
  always_comb begin
    mag_a = (is_signed && dividend[XLEN-1]) ? -dividend : dividend;
    mag_b = (is_signed && divisor[XLEN-1]) ? -divisor : divisor;
    // Sign extension decides how many bits need no iteration
    if (is_signed ? (&dividend[31:7] || ~|dividend[31:7]) :
        ~|dividend[31:8]) begin
      rpt = DIV_RPT_8;
      skip = DIV_SKIP_8;
    end else if (is_signed ? (&dividend[31:15] || ~|dividend[31:15]) :
                 ~|dividend[31:16]) begin
      rpt = DIV_RPT_16;
      skip = DIV_SKIP_16;
    end else if (is_signed ? (&dividend[31:23] || ~|dividend[31:23]) :
                 ~|dividend[31:24]) begin
      rpt = DIV_RPT_24;
      skip = DIV_SKIP_24;
    end else begin
      rpt = DIV_RPT_32;
      skip = DIV_SKIP_32;
    end
    sh = {s_r.rem, s_r.q[XLEN-1]};
    ge = sh >= {1'b0, s_r.d};
    // Last step kept apart so a start in the finishing cycle cannot hide it
    it_rem = s_r.rem;
    it_q = s_r.q;
    if (s_r.cnt != '0 && s_r.pad == '0) begin
      it_rem = ge ? XLEN'(sh - {1'b0, s_r.d}) : sh[XLEN-1:0];
      it_q = {s_r.q[XLEN-2:0], ge};
    end
    s_nxt = s_r;
    if (start) begin
      s_nxt.cnt = rpt;
      // Short classes spend spare cycles first so timing stays fixed
      s_nxt.pad = rpt - (DIV_BITS - skip);
      s_nxt.rem = '0;
      s_nxt.q = mag_a << skip;
      s_nxt.d = mag_b;
      s_nxt.neg_q = is_signed && (dividend[XLEN-1] ^ divisor[XLEN-1]);
      s_nxt.neg_r = is_signed && dividend[XLEN-1];
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 6'h01;
      if (s_r.pad != '0) begin
        s_nxt.pad = s_r.pad - 6'h01;
      end else begin
        s_nxt.rem = it_rem;
        s_nxt.q = it_q;
      end
    end
    fin = s_r.cnt == 6'h01;
    cnt_nxt = s_nxt.cnt;
    quot = s_r.neg_q ? -it_q : it_q;
    remd = s_r.neg_r ? -it_rem : it_rem;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Checks, clock enable held high
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_div8_time;
    start && clk_en && rpt == DIV_RPT_8 |-> ##11 fin;
  endproperty
  a_div8_time: assert property (p_div8_time)
    else $error("div8 time");

  property p_div32_time;
    start && clk_en && rpt == DIV_RPT_32 |-> ##32 fin;
  endproperty
  a_div32_time: assert property (p_div32_time)
    else $error("div32 time");

  property p_skip16;
    start && clk_en && rpt == DIV_RPT_16 |=> s_r.q == ($past(mag_a) << 15);
  endproperty
  a_skip16: assert property (p_skip16)
    else $error("skip16 wrong");

  property p_one_bit;
    clk_en && !start && s_r.cnt != '0 && s_r.pad == '0
      |=> s_r.q[XLEN-1:1] == $past(s_r.q[XLEN-2:0]);
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("not one bit");
endmodule

// *** core_integer_and_product_quotient_unit.sv ***
// Integer execution datapath with product/quotient engine
`timescale 1ns/1ps
// Overview of operation
// - Thirty-two 32-bit general registers for integer work and addresses.
// - A second full register set serves as shadow for interrupts.
// - Two reads, one write, newest write forwarded to readers.
// - Logical, shift, add and subtract finish in one cycle.
// - Own 32-bit adder forms data addresses.
// - Leading zero and leading one counts come from one detector.
// - Engine keeps running while the integer pipe stalls.
// - 32x16 multiplier; operand_b width picks one or two passes.
// - Narrow multiply each clock, wide one every other clock.
// - Division yields one quotient bit per clock.
// - Divider skips 23, 15 or 7 iterations by operand_a width.
// - Engine instructions wait until a division's last cycle; pair readers wait for its end.
// - Pair ops latency/repeat 1 or 2; general product 2/1 or 3/2.
// - Division latency/repeat 12/11, 19/18, 26/25, 33/32.
// - Results land in upper/bottom pair; moves copy them out.
// - General product writes its low word to a register.
// - Accumulate adds the product to the pair.
// - Deduct subtracts the product from the pair.
module core_integer_and_product_quotient_unit import pq_pkg::*; (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Issue from the integer pipe
  input wire issue_t iss,
  input wire logic pipe_stall,
  // Results
  output wb_t wb,
  output logic [XLEN-1:0] data_addr,
  output logic data_addr_v,
  output logic [XLEN-1:0] upper_result,
  output logic [XLEN-1:0] bottom_result,
  // Issue holds
  output logic eng_hold,
  output logic pair_hold,
  output logic gen_hold
);
  typedef struct packed {
    wb_t res;
    wb_t stg;
    logic ad_v;
    logic [XLEN-1:0] ad;
    logic [XLEN-1:0] upper;
    logic [XLEN-1:0] bottom;
    logic m2;
    op_t mop;
    logic mset;
    logic [RIDX-1:0] mrd;
    logic [XLEN:0] ma;
    logic [HALF:0] mb;
    logic [2*XLEN-1:0] part;
    logic eng_hold;
    logic pair_hold;
    logic gen_hold;
  } top_st_t;

  top_st_t s_r;
  top_st_t s_nxt;
  logic [1:0][RIDX-1:0] ridx;
  logic [1:0][XLEN-1:0] opnd;
  logic is_eng;
  logic rd_pair;
  logic to_gen;
  logic is_mul;
  logic take;
  logic div_go;
  logic sgn;
  logic fits16;
  logic dv_fin;
  logic [CNTW-1:0] dv_cnt_nxt;
  logic [XLEN-1:0] dv_q;
  logic [XLEN-1:0] dv_r;
  logic [XLEN-1:0] alu;
  logic [XLEN:0] mul_a;
  logic [HALF:0] mul_b;
  logic signed [XLEN+HALF+1:0] prod;
  logic [2*XLEN-1:0] full;
  logic [2*XLEN-1:0] acc;
  op_t fop;

  function automatic logic [5:0] lead_count(input logic [XLEN-1:0] v,
                                            input logic bit_val);
    logic done;
    lead_count = '0;
    done = 1'b0;
    for (int i = XLEN - 1; i >= 0; i--) begin
      if (!done && v[i] == bit_val) begin
        lead_count = lead_count + 6'h01;
      end else begin
        done = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // Register file and divider
  assign ridx[0] = iss.ra;
  assign ridx[1] = iss.rb;

  general_register_file u_rf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .rd_set(iss.set),
    .rd_idx(ridx),
    .rd_data(opnd),
    .wr(s_r.res)
  );

  quotient_iterator u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(div_go),
    .is_signed(iss.op == OP_QUOT),
    .dividend(opnd[0]),
    .divisor(opnd[1]),
    .fin(dv_fin),
    .cnt_nxt(dv_cnt_nxt),
    .quot(dv_q),
    .remd(dv_r)
  );

  // ==========================================================
  // Issue acceptance
  assign is_eng = iss.op inside {[OP_MOVE_UPPER:OP_QUOT_U]};
  assign rd_pair = iss.op inside {OP_MOVE_UPPER, OP_MOVE_BOTTOM,
                                  [OP_ACC_PROD:OP_DED_PROD_U]};
  assign to_gen = iss.op inside {[OP_AND:OP_LEAD_ONE], OP_MOVE_UPPER,
                                 OP_MOVE_BOTTOM};
  assign is_mul = iss.op inside {[OP_PROD_PAIR:OP_PROD_GEN]};
  // Holds are registered, so issue never waits on a long path
  assign take = iss.valid && !pipe_stall &&
                !(is_eng && s_r.eng_hold) &&
                !(rd_pair && s_r.pair_hold) &&
                !(to_gen && s_r.gen_hold);
  assign div_go = take && iss.op inside {OP_QUOT, OP_QUOT_U};

  // ==========================================================
  // Datapath and next state
  always_comb begin
    unique case (iss.op)
      OP_AND: alu = opnd[0] & opnd[1];
      OP_OR: alu = opnd[0] | opnd[1];
      OP_XOR: alu = opnd[0] ^ opnd[1];
      OP_NOR: alu = ~(opnd[0] | opnd[1]);
      OP_SLL: alu = opnd[0] << opnd[1][4:0];
      OP_SRL: alu = opnd[0] >> opnd[1][4:0];
      OP_SRA: alu = $signed(opnd[0]) >>> opnd[1][4:0];
      OP_ADD: alu = opnd[0] + opnd[1];
      OP_SUB: alu = opnd[0] - opnd[1];
      OP_LEAD_ZERO: alu = XLEN'(lead_count(opnd[0], 1'b0));
      OP_LEAD_ONE: alu = XLEN'(lead_count(opnd[0], 1'b1));
      OP_MOVE_UPPER: alu = s_r.upper;
      OP_MOVE_BOTTOM: alu = s_r.bottom;
      default: alu = '0;
    endcase

    // One 33x17 signed array serves both signednesses
    fop = s_r.m2 ? s_r.mop : iss.op;
    sgn = fop inside {OP_PROD_PAIR, OP_ACC_PROD, OP_DED_PROD,
                      OP_PROD_GEN};
    fits16 = sgn ? (&opnd[1][31:15] || ~|opnd[1][31:15]) :
             ~|opnd[1][31:16];
    mul_a = s_r.m2 ? s_r.ma : {sgn && opnd[0][XLEN-1], opnd[0]};
    mul_b = s_r.m2 ? s_r.mb :
            {sgn && fits16 && opnd[1][HALF-1], opnd[1][HALF-1:0]};
    prod = $signed(mul_a) * $signed(mul_b);
    full = (2 * XLEN)'(prod);
    if (s_r.m2) begin
      full = s_r.part + (full << HALF);
    end
    acc = {s_r.upper, s_r.bottom};
    if (fop inside {OP_ACC_PROD, OP_ACC_PROD_U}) begin
      acc = acc + full;
    end else if (fop inside {OP_DED_PROD, OP_DED_PROD_U}) begin
      acc = acc - full;
    end else begin
      acc = full;
    end

    s_nxt = s_r;
    s_nxt.res.en = 1'b0;
    s_nxt.stg.en = 1'b0;
    s_nxt.ad_v = 1'b0;
    if (s_r.stg.en) begin
      s_nxt.res = s_r.stg;
    end
    if (dv_fin) begin
      s_nxt.upper = dv_r;
      s_nxt.bottom = dv_q;
    end
    // Second pass ignores pipe stalls
    if (s_r.m2) begin
      s_nxt.m2 = 1'b0;
      if (s_r.mop == OP_PROD_GEN) begin
        s_nxt.stg = '{1'b1, s_r.mset, s_r.mrd, full[XLEN-1:0]};
      end else begin
        {s_nxt.upper, s_nxt.bottom} = acc;
      end
    end
    if (take) begin
      if (to_gen) begin
        s_nxt.res = '{1'b1, iss.set, iss.rd, alu};
      end
      if (iss.op == OP_DADDR) begin
        s_nxt.ad_v = 1'b1;
        s_nxt.ad = opnd[0] + iss.imm;
      end
      if (is_mul && !fits16) begin
        s_nxt.m2 = 1'b1;
        s_nxt.mop = iss.op;
        s_nxt.mset = iss.set;
        s_nxt.mrd = iss.rd;
        s_nxt.ma = mul_a;
        s_nxt.mb = {sgn && opnd[1][XLEN-1], opnd[1][XLEN-1:HALF]};
        s_nxt.part = full;
      end else if (is_mul && iss.op == OP_PROD_GEN) begin
        s_nxt.stg = '{1'b1, iss.set, iss.rd, full[XLEN-1:0]};
      end else if (is_mul) begin
        {s_nxt.upper, s_nxt.bottom} = acc;
      end
    end
    // Last divide cycle admits new work but not pair readers
    s_nxt.eng_hold = s_nxt.m2 || dv_cnt_nxt > 6'h01;
    s_nxt.pair_hold = s_nxt.m2 || dv_cnt_nxt != '0;
    s_nxt.gen_hold = s_nxt.stg.en;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign wb = s_r.res;
  assign data_addr = s_r.ad;
  assign data_addr_v = s_r.ad_v;
  assign upper_result = s_r.upper;
  assign bottom_result = s_r.bottom;
  assign eng_hold = s_r.eng_hold;
  assign pair_hold = s_r.pair_hold;
  assign gen_hold = s_r.gen_hold;

  // ==========================================================
  // Checks, clock enable held high
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_store;
    clk_en && s_r.res.en && s_r.res.idx != '0 ##1
    (clk_en && !s_r.res.en && iss.ra == $past(s_r.res.idx) &&
     iss.set == $past(s_r.res.set)) |-> opnd[0] == $past(s_r.res.data);
  endproperty
  a_store: assert property (p_store)
    else $error("stored word lost");

  property p_alu_one;
    clk_en && take && to_gen |=> wb.en && wb.idx == $past(iss.rd);
  endproperty
  a_alu_one: assert property (p_alu_one) else $error("alu late");

  property p_daddr;
    clk_en && take && iss.op == OP_DADDR
      |=> data_addr_v && data_addr == $past(opnd[0]) + $past(iss.imm);
  endproperty
  a_daddr: assert property (p_daddr) else $error("address wrong");

  property p_lzero;
    clk_en && take && iss.op == OP_LEAD_ZERO && opnd[0] == '0
      |=> wb.data == 32'h0000_0020;
  endproperty
  a_lzero: assert property (p_lzero)
    else $error("zero count wrong");

  property p_stall_adv;
    clk_en && s_r.m2 && pipe_stall |=> !s_r.m2 && !eng_hold;
  endproperty
  a_stall_adv: assert property (p_stall_adv)
    else $error("engine stalled");

  property p_wide_rpt;
    clk_en && take && is_mul && !fits16 |=> eng_hold ##1 !s_r.m2;
  endproperty
  a_wide_rpt: assert property (p_wide_rpt)
    else $error("wide repeat");

  property p_div_hold;
    clk_en && div_go |=> eng_hold [*8];
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("no div hold");

  property p_gen_lat;
    clk_en && take && iss.op == OP_PROD_GEN && fits16
      |-> ##2 wb.en && wb.idx == $past(iss.rd, 2);
  endproperty
  a_gen_lat: assert property (p_gen_lat)
    else $error("product late");

  property p_move_bot;
    clk_en && take && iss.op == OP_MOVE_BOTTOM
      |=> wb.data == $past(s_r.bottom);
  endproperty
  a_move_bot: assert property (p_move_bot)
    else $error("move wrong");

  property p_div_res;
    clk_en && dv_fin && !take |=> bottom_result == $past(dv_q);
  endproperty
  a_div_res: assert property (p_div_res)
    else $error("quotient lost");

  c_div: cover property (div_go);
  c_wide: cover property (take && is_mul && !fits16);
  c_ded: cover property (take && iss.op == OP_DED_PROD);
  c_stall: cover property (s_r.m2 && pipe_stall);
endmodule

// *** pipe_issuer.sv ***
// Integer pipe model that holds each issue until the unit takes it
`timescale 1ns/1ps
module pipe_issuer import pq_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Unit status
  input wire logic clk_en,
  input wire logic pipe_stall,
  input wire logic eng_hold,
  input wire logic pair_hold,
  input wire logic gen_hold,
  // Issue
  output issue_t iss
);
  // ==========================================================
  // Pending issues and the cycles at which they were taken
  issue_t q[$];
  int take_cyc[$];
  int cyc;
  logic took;

  function automatic logic held(issue_t x);
    logic pr;
    logic gr;
    pr = x.op inside {OP_MOVE_UPPER, OP_MOVE_BOTTOM, OP_ACC_PROD,
      OP_ACC_PROD_U, OP_DED_PROD, OP_DED_PROD_U};
    gr = x.op <= OP_LEAD_ONE || x.op inside {OP_MOVE_UPPER, OP_MOVE_BOTTOM};
    return (x.op >= OP_MOVE_UPPER && eng_hold) || (pr && pair_hold) ||
      (gr && gen_hold);
  endfunction

  // ==========================================================
  // Issue register; idle fields toggle so stale values never match
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iss <= '0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      took = iss.valid && clk_en && !pipe_stall && !held(iss);
      if (took) begin
        take_cyc.push_back(cyc);
      end
      if (!iss.valid || took) begin
        if (q.size() > 0) begin
          iss <= q.pop_front();
        end else begin
          iss <= {1'b0, ~iss[52:0]};
        end
      end
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the integer and product/quotient unit
`timescale 1ns/1ps
module testbench import pq_pkg::*;;
  // ==========================================================
  // Clock, reset and hookup
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic pipe_stall = 1'b0;
  logic stall_rand = 1'b0;
  issue_t iss;
  wb_t wb;
  logic [XLEN-1:0] data_addr, upper_result, bottom_result;
  logic data_addr_v, eng_hold, pair_hold, gen_hold;
  int bad_count = 0;
  int checks = 0;

  always #5 ref_clk = ~ref_clk;

  core_integer_and_product_quotient_unit DUT (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(clk_en), .iss(iss), .pipe_stall(pipe_stall),
    .wb(wb), .data_addr(data_addr), .data_addr_v(data_addr_v),
    .upper_result(upper_result), .bottom_result(bottom_result),
    .eng_hold(eng_hold), .pair_hold(pair_hold), .gen_hold(gen_hold));

  pipe_issuer issuer (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .pipe_stall(pipe_stall), .eng_hold(eng_hold), .pair_hold(pair_hold),
    .gen_hold(gen_hold), .iss(iss));

  // ==========================================================
  // Reference model: both register sets and the result pair
  logic [31:0] rf [2][32] = '{default: '0};
  logic [63:0] pair = '0;
  logic [37:0] exp_wb[$];
  logic [31:0] exp_addr[$];
  logic [63:0] e_wb;

  task automatic chk_val(string what, logic [63:0] e, logic [63:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask

  task automatic chk_gap(int e, int s);
    checks++;
    if (s != e) begin
      bad_count++;
      $display("unexpected issue gap: expected %0d seen %0d", e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] lead(logic [31:0] v);
    int n;
    n = 0;
    while (n < 32 && !v[31-n]) n++;
    return 32'(n);
  endfunction

  // Model is advanced at queue time; the unit is in-order, so it matches
  task automatic put(op_t op, logic s, logic [4:0] ra, logic [4:0] rb,
                     logic [4:0] rd, logic [31:0] imm);
    logic [31:0] a, b, r;
    logic [63:0] ps, pu;
    a = rf[s][ra];
    b = rf[s][rb];
    ps = 64'($signed(a)) * 64'($signed(b));
    pu = {32'h0000_0000, a} * {32'h0000_0000, b};
    r = '0;
    case (op)
      OP_AND: r = a & b;
      OP_OR: r = a | b;
      OP_XOR: r = a ^ b;
      OP_NOR: r = ~(a | b);
      OP_SLL: r = a << b[4:0];
      OP_SRL: r = a >> b[4:0];
      OP_SRA: r = $signed(a) >>> b[4:0];
      OP_ADD: r = a + b;
      OP_SUB: r = a - b;
      OP_LEAD_ZERO: r = lead(a);
      OP_LEAD_ONE: r = lead(~a);
      OP_DADDR: exp_addr.push_back(a + imm);
      OP_MOVE_UPPER: r = pair[63:32];
      OP_MOVE_BOTTOM: r = pair[31:0];
      OP_PROD_PAIR: pair = ps;
      OP_PROD_PAIR_U: pair = pu;
      OP_ACC_PROD: pair = pair + ps;
      OP_ACC_PROD_U: pair = pair + pu;
      OP_DED_PROD: pair = pair - ps;
      OP_DED_PROD_U: pair = pair - pu;
      OP_PROD_GEN: r = ps[31:0];
      OP_QUOT: pair = {32'($signed(a) % $signed(b)),
                       32'($signed(a) / $signed(b))};
      default: pair = {a % b, a / b};
    endcase
    if (op <= OP_LEAD_ONE || op inside {OP_MOVE_UPPER, OP_MOVE_BOTTOM,
        OP_PROD_GEN}) begin
      if (rd != 0) rf[s][rd] = r;
      exp_wb.push_back({s, rd, r});
    end
    issuer.q.push_back({1'b1, op, s, ra, rb, rd, imm});
  endtask

  // Constants are built by doubling, since no op loads an immediate
  task automatic load(logic s, logic [4:0] rd, logic [31:0] v);
    put(OP_AND, s, 0, 0, rd, 0);
    for (int i = 31; i >= 0; i--) begin
      put(OP_ADD, s, rd, rd, rd, 0);
      if (v[i]) put(OP_ADD, s, rd, 31, rd, 0);
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while ((issuer.q.size() || iss.valid || eng_hold || pair_hold ||
            gen_hold) && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      chk_val("completion wait", 0, 1);
      tally_and_finish();
    end
    repeat (4) @(posedge ref_clk);
    #1;
    chk_val("pair", pair, {upper_result, bottom_result});
    chk_val("pending", 0, 64'(exp_wb.size() + exp_addr.size()));
  endtask

  task automatic gap(op_t o1, op_t o2, logic [31:0] a, logic [31:0] b,
                     int e);
    int n;
    load(0, 1, a);
    load(0, 2, b);
    settle();
    n = issuer.take_cyc.size();
    put(o1, 0, 1, 2, 7, 0);
    put(o2, 0, 1, 2, 8, 0);
    settle();
    chk_gap(e, issuer.take_cyc[n+1] - issuer.take_cyc[n]);
  endtask

  // ==========================================================
  // Result monitor
  always @(posedge ref_clk) begin
    if (rst_n && wb.en === 1'b1) begin
      e_wb = exp_wb.size() ? 64'(exp_wb.pop_front()) : 'x;
      chk_val("wb", e_wb, 64'({wb.set, wb.idx, wb.data}));
    end
    if (rst_n && data_addr_v === 1'b1) begin
      e_wb = exp_addr.size() ? 64'(exp_addr.pop_front()) : 'x;
      chk_val("data_addr", e_wb, 64'(data_addr));
    end
  end

  // Random stalls only gate issue; the engine must carry on regardless
  always @(posedge ref_clk) begin
    if (stall_rand) pipe_stall <= ($urandom % 3) == 0;
  end

  // ==========================================================
  // Tests
  initial begin
    logic [31:0] a, b;
    logic [63:0] old;
    int n;
    int k;
    void'($urandom(32'hbb8d));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      put(OP_NOR, s[0], 0, 0, 30, 0);
      put(OP_SUB, s[0], 0, 30, 31, 0);
    end
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? '0 : i == 1 ? '1 : $urandom;
      load(i[0], 1, a);
      load(i[0], 2, $urandom);
      for (int op = 0; op <= 10; op++)
        put(op_t'(op), i[0], 1, 2, 5'(3 + op), 0);
      put(OP_DADDR, i[0], 1, 0, 0, $urandom);
    end
    put(OP_ADD, 0, 1, 0, 20, 0);
    put(OP_ADD, 1, 1, 0, 20, 0);
    settle();
    $display("test alu done");
    stall_rand = 1'b1;
    for (int i = 0; i < 18; i++) begin
      b = i >= 9 ? $urandom : 32'($signed(16'($urandom)));
      load(0, 1, $urandom);
      load(0, 2, b | 32'h0000_0001);
      put(op_t'(14 + i % 9), 0, 1, 2, 7, 0);
      put(OP_MOVE_UPPER, 0, 0, 0, 5, 0);
      put(OP_MOVE_BOTTOM, 0, 0, 0, 6, 0);
      settle();
    end
    stall_rand = 1'b0;
    @(posedge ref_clk);
    pipe_stall <= 1'b0;
    $display("test engine done");
    for (int c = 0; c < 4; c++) begin
      a = (32'h0000_0001 << (8 * c + 7)) - 1;
      gap(OP_QUOT_U, OP_ACC_PROD, a, 3, 12 + 7 * c);
      gap(OP_QUOT, OP_PROD_PAIR, ~a, 3, 11 + 7 * c);
    end
    gap(OP_QUOT, OP_MOVE_BOTTOM, 32'h0000_007f, 3, 12);
    gap(OP_QUOT_U, OP_QUOT, 32'h0000_00ff, 3, 11);
    gap(OP_PROD_PAIR, OP_PROD_PAIR, $urandom, 32'h0000_7fff, 1);
    gap(OP_PROD_PAIR, OP_DED_PROD, $urandom, 32'h0001_0000, 2);
    gap(OP_ACC_PROD_U, OP_MOVE_UPPER, $urandom, 32'h0001_0000, 2);
    gap(OP_PROD_GEN, OP_AND, $urandom, 32'hffff_8000, 2);
    $display("test timing done");
    load(0, 1, 32'h7fff_ffff);
    load(0, 2, 3);
    settle();
    n = issuer.take_cyc.size();
    old = pair;
    put(OP_QUOT, 0, 1, 2, 0, 0);
    k = 0;
    while (issuer.take_cyc.size() == n && k < 50) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 50) chk_val("take wait", 0, 1);
    @(posedge ref_clk);
    pipe_stall <= 1'b1;
    repeat (30) @(posedge ref_clk);
    #1;
    chk_val("pair early", old, {upper_result, bottom_result});
    @(posedge ref_clk);
    #1;
    chk_val("pair late", pair, {upper_result, bottom_result});
    @(posedge ref_clk);
    pipe_stall <= 1'b0;
    settle();
    $display("test stall done");
    tally_and_finish();
  end
endmodule
